//--- hdl/pfs_pad_mux.sv
module pfs_pad_mux
    import pfs_pkg::*;
(
    input  wire logic                          ref_clk,
    input  wire logic                          nrst,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [PFS_ADR_W-1:0]          wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    input  wire logic                          boot_active,
    input  wire logic [PFS_NPADS-1:0][3:0]     periph_out,
    input  wire logic [PFS_NPADS-1:0][3:0]     periph_oe,
    output logic      [PFS_NPADS-1:0]          periph_in,
    output logic      [PFS_NPADS-1:0]          wakeup_line,
    output logic      [PFS_NPADS-1:0]          external_irq_line,
    output logic                               nmi_req,
    input  wire logic [PFS_NPADS-1:0]          pad_in,
    output logic      [PFS_NPADS-1:0]          pad_out,
    output logic      [PFS_NPADS-1:0]          pad_oe,
    output logic      [PFS_NPADS-1:0]          pad_pull_up,
    output logic      [PFS_NPADS-1:0]          pad_drive_fast
);

    logic [PFS_NPADS-1:0][15:0] cfg_all;
    logic [PFS_NPADS-1:0]       sync_a;
    logic [PFS_NPADS-1:0]       sync_b;
    logic [PFS_NPADS-1:0]       sync_c;
    logic [PFS_NPADS-1:0]       level;
    logic                       bus_req;
    logic                       bus_hit;
    logic [2:0]                 bus_idx;
    logic                       wr_en;
    logic [15:0]                wr_mask;
    logic [15:0]                next_rdata;

    // helper: slot of a pad
    function automatic pfs_slot_e slot_of(input logic [15:0] cfg);
        return pfs_slot_e'(cfg[PFS_AF_LSB +: 2]);
    endfunction

    // helper: nmi input owns the pad
    function automatic logic nmi_owns(input int idx, input logic [15:0] cfg);
        return (idx == PFS_PAD_NMI) && cfg[PFS_BIT_NMI];
    endfunction

    // helper: boot-only function selected after boot
    function automatic logic boot_blocked(input int idx, input logic [15:0] cfg,
                                          input logic booting);
        return PFS_BOOT_MASK[idx] && (slot_of(cfg) == PFS_BOOT_SLOT) && !booting;
    endfunction

    // ---------------- bus slave ----------------
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_hit = (wb_adr_i[PFS_ADR_W-1:5] == 3'h0);
    assign bus_idx = wb_adr_i[4:2];
    // write lands at the edge where the master sees ack
    assign wr_en   = wb_cyc_i && wb_stb_i && wb_ack_o && bus_hit && wb_we_i;
    assign wr_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & PFS_WMASK;

    always_comb
    begin
        next_rdata = 16'h0000;
        if (bus_hit)
        begin
            next_rdata = cfg_all[bus_idx] & PFS_WMASK;
            next_rdata[PFS_TYPE_LSB +: 3] = pfs_pad_type(int'(bus_idx)); // R15
            next_rdata[PFS_BIT_LEVEL] = level[bus_idx];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (bus_req && !wb_we_i)
        begin
            wb_dat_o <= {16'h0000, next_rdata};
        end
    end

    pfs_cfg_store u_store (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .wr_en   (wr_en),
        .wr_idx  (bus_idx),
        .wr_data (wb_dat_i[15:0]),
        .wr_mask (wr_mask),
        .cfg_all (cfg_all)
    ); // R02 R07

    // ---------------- pad input sampling ----------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
        end
        else
        begin
            sync_a <= pad_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // level follows once second and third stage agree
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            level <= '0;
        end
        else
        begin
            for (int i = 0; i < PFS_NPADS; i++)
            begin
                if (sync_b[i] == sync_c[i])
                begin
                    level[i] <= sync_b[i];
                end
            end
        end
    end

    // ---------------- inward routing ----------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            periph_in         <= '0;
            wakeup_line       <= '0;
            external_irq_line <= '0;
            nmi_req           <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < PFS_NPADS; i++)
            begin
                periph_in[i]         <= level[i] && cfg_all[i][PFS_BIT_IBE];
                wakeup_line[i]       <= level[i] && PFS_WAKE_MASK[i]; // R16
                external_irq_line[i] <= level[i] &&
                                        (PFS_WAKE_MASK[i] || PFS_EXTERNAL_IRQ_LINE_MASK[i]); // R13
            end
            nmi_req <= level[PFS_PAD_NMI] && nmi_owns(PFS_PAD_NMI, cfg_all[PFS_PAD_NMI]); // R03
        end
    end

    // ---------------- outward routing ----------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pad_out <= '0;
            pad_oe  <= '0; // R17
        end
        else
        begin
            for (int i = 0; i < PFS_NPADS; i++)
            begin
                if (nmi_owns(i, cfg_all[i]) || boot_blocked(i, cfg_all[i], boot_active))
                begin
                    pad_out[i] <= 1'b0; // R03 R14
                    pad_oe[i]  <= 1'b0;
                end
                else if (slot_of(cfg_all[i]) == alt_slot_zero)
                begin
                    pad_out[i] <= periph_out[i][0];
                    pad_oe[i]  <= cfg_all[i][PFS_BIT_OBE]; // R10
                end
                else
                begin
                    pad_out[i] <= periph_out[i][slot_of(cfg_all[i])]; // R16
                    pad_oe[i]  <= periph_oe[i][slot_of(cfg_all[i])]; // R09
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pad_pull_up    <= PFS_PULL_RST; // R06
            pad_drive_fast <= '0; // R11
        end
        else
        begin
            for (int i = 0; i < PFS_NPADS; i++)
            begin
                pad_pull_up[i]    <= cfg_all[i][PFS_BIT_PULL];
                pad_drive_fast[i] <= cfg_all[i][PFS_BIT_FAST] &&
                                     (pfs_pad_type(i) == pad_fast);
            end
        end
    end

    // ---------------- checks ----------------
    logic fresh;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fresh <= 1'b1;
        end
        else
        begin
            fresh <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_reset_slots: assert property (fresh |-> // R01
        slot_of(cfg_all[0]) == alt_slot_zero && slot_of(cfg_all[PFS_PAD_EXTERNAL_IRQ_LINE]) == alt_slot_zero)
        else $error("pad not in slot zero after reset");
    a_reset_scan: assert property (fresh |-> // R05
        slot_of(cfg_all[PFS_PAD_TDI]) == alt_slot_one && cfg_all[PFS_PAD_TDI][PFS_BIT_IBE])
        else $error("test data input pad wrong after reset");
    a_reset_tdo: assert property (fresh |-> // R08
        slot_of(cfg_all[PFS_PAD_TDO]) == alt_slot_two && cfg_all[PFS_PAD_TDO][PFS_BIT_OBE]
        && !pad_drive_fast[PFS_PAD_TDO])
        else $error("test data output pad wrong after reset");
    a_reset_pull: assert property (fresh |-> pad_pull_up == PFS_PULL_RST // R06
        && !pad_oe[PFS_PAD_TCK] && !pad_oe[PFS_PAD_TMS])
        else $error("scan clock or mode pads wrong after reset");
    a_reset_tristate: assert property (fresh |-> pad_oe == '0) // R17
        else $error("pad driven right after reset");
    a_nmi_priority: assert property (nmi_owns(PFS_PAD_NMI, cfg_all[PFS_PAD_NMI]) // R03
        |=> !pad_oe[PFS_PAD_NMI] && nmi_req == $past(level[PFS_PAD_NMI]))
        else $error("nmi selection did not override slot");
    a_gpio_obe: assert property (slot_of(cfg_all[PFS_PAD_TDO]) == alt_slot_zero // R10
        && cfg_all[PFS_PAD_TDO][PFS_BIT_OBE] |=> pad_oe[PFS_PAD_TDO])
        else $error("slot zero pad with enable set not driving");
    a_alt_ignores_obe: assert property (slot_of(cfg_all[PFS_PAD_TDO]) == alt_slot_two // R09
        |=> pad_oe[PFS_PAD_TDO] == $past(periph_oe[PFS_PAD_TDO][2]))
        else $error("slot two pad enable not from function");
    a_boot_only: assert property (!boot_active // R14
        && slot_of(cfg_all[PFS_PAD_WAKE]) == PFS_BOOT_SLOT |=> !pad_oe[PFS_PAD_WAKE])
        else $error("boot-only function drove after boot");
    a_wake_irq: assert property (##1 external_irq_line[PFS_PAD_WAKE] // R13
        == wakeup_line[PFS_PAD_WAKE] && wakeup_line[PFS_PAD_WAKE] == $past(level[PFS_PAD_WAKE]))
        else $error("wakeup pad lost interrupt path");
    a_bus_ack: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o) // R02
        else $error("bus ack not a single cycle");
    a_type_read: assert property (bus_req && bus_hit && !wb_we_i // R15
        |=> wb_dat_o[PFS_TYPE_LSB +: 3] == pfs_pad_type(int'($past(bus_idx))))
        else $error("pad type read back wrong");

    c_write: cover property (wr_en && wb_sel_i[0]);
    c_nmi_sel: cover property (nmi_owns(PFS_PAD_NMI, cfg_all[PFS_PAD_NMI]));
    c_tdo_gpio: cover property (slot_of(cfg_all[PFS_PAD_TDO]) == alt_slot_zero ##1
                                pad_oe[PFS_PAD_TDO]);
    c_boot_use: cover property (boot_active && slot_of(cfg_all[PFS_PAD_WAKE]) == PFS_BOOT_SLOT);

endmodule // pfs_pad_mux

//--- hdl/pfs_pkg.sv
//Function
//R01: after reset every pad sits in alternate slot zero unless that pad has its own reset choice.
//R02: each pad offers a set of alternate functions picked through its pad config register.
//R03: a selected non-maskable interrupt input wins and the slot field is ignored.
//R04: out of reset every pad is general-purpose I/O except the port C and port H test pins.
//R05: after reset port C pins 0 and 1 carry the scan test data input and test data output.
//R06: after reset port H pins 9 and 10 carry scan clock and mode select, inputs with pull-ups.
//R07: software moves the four test pins to general-purpose I/O itself when it needs them so.
//R08: port C pin 1 sits in alternate slot two after reset, driving test data output.
//R09: port C pin 1 output buffer enable resets to one but has no effect while in slot two.
//R10: once software selects slot zero on port C pin 1 its output buffer is enabled at once.
//R11: port C pin 1 supports fast and medium drive and resets to medium.
//R12: for flagged functions software keeps the input buffer enable bit cleared.
//R13: every pad carrying a wakeup input can also raise an external interrupt.
//R14: functions flagged as boot-only work only while the device is booting.
//R15: each pad reports its type: fast, medium, slow, analog input or analog input/output.
//R16: a two-bit slot field picks output slots zero to three; slotless inputs always see the pad.
//R17: all pads except scan clock and mode select are tristated during and after reset; the code also tristates scan clock and mode select during reset.
package pfs_pkg;

    localparam int          PFS_NPADS     = 8;
    localparam int          PFS_ADR_W     = 8;
    localparam logic [15:0] PFS_WMASK     = 16'h031f;

    // pad config register fields
    localparam int          PFS_AF_LSB    = 0;
    localparam int          PFS_BIT_NMI   = 2;
    localparam int          PFS_BIT_PULL  = 3;
    localparam int          PFS_BIT_FAST  = 4;
    localparam int          PFS_BIT_IBE   = 8;
    localparam int          PFS_BIT_OBE   = 9;
    localparam int          PFS_TYPE_LSB  = 12;
    localparam int          PFS_BIT_LEVEL = 15;

    // pad roles
    localparam int          PFS_PAD_NMI   = 1;
    localparam int          PFS_PAD_WAKE  = 2;
    localparam int          PFS_PAD_EXTERNAL_IRQ_LINE  = 3;
    localparam int          PFS_PAD_TDI   = 4;
    localparam int          PFS_PAD_TDO   = 5;
    localparam int          PFS_PAD_TCK   = 6;
    localparam int          PFS_PAD_TMS   = 7;
    localparam logic [7:0]  PFS_WAKE_MASK = 8'h06;
    localparam logic [7:0]  PFS_EXTERNAL_IRQ_LINE_MASK = 8'h08;
    localparam logic [7:0]  PFS_BOOT_MASK = 8'h04;
    localparam logic [7:0]  PFS_PULL_RST  = 8'hc0;

    // reset values
    localparam logic [15:0] PFS_RST_GPIO  = 16'h0000;
    localparam logic [15:0] PFS_RST_TDI   = 16'h0101;
    localparam logic [15:0] PFS_RST_TDO   = 16'h0202;
    localparam logic [15:0] PFS_RST_SCAN  = 16'h010a;

    typedef enum logic [1:0] {
        alt_slot_zero  = 2'h0,
        alt_slot_one   = 2'h1,
        alt_slot_two   = 2'h2,
        alt_slot_three = 2'h3
    } pfs_slot_e;

    localparam pfs_slot_e   PFS_BOOT_SLOT = alt_slot_three;

    typedef enum logic [2:0] {
        pad_fast      = 3'h0,
        pad_medium    = 3'h1,
        pad_slow      = 3'h2,
        pad_in_analog = 3'h3,
        pad_io_analog = 3'h4
    } pfs_pad_e;

    function automatic logic [15:0] pfs_reset_cfg(input int idx);
        unique case (idx)
            PFS_PAD_TDI: return PFS_RST_TDI;
            PFS_PAD_TDO: return PFS_RST_TDO;
            PFS_PAD_TCK,
            PFS_PAD_TMS: return PFS_RST_SCAN;
            default:     return PFS_RST_GPIO;
        endcase
    endfunction

    function automatic pfs_pad_e pfs_pad_type(input int idx);
        unique case (idx)
            0, 4, 7: return pad_medium;
            3:       return pad_io_analog;
            5:       return pad_fast;
            default: return pad_slow;
        endcase
    endfunction

endpackage

//--- hdl/pfs_cfg_store.sv
module pfs_cfg_store
    import pfs_pkg::*;
(
    input  wire logic                         ref_clk,
    input  wire logic                         nrst,
    input  wire logic                         wr_en,
    input  wire logic [2:0]                   wr_idx,
    input  wire logic [15:0]                  wr_data,
    input  wire logic [15:0]                  wr_mask,
    output logic      [PFS_NPADS-1:0][15:0]   cfg_all
);

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < PFS_NPADS; i++)
            begin
                cfg_all[i] <= pfs_reset_cfg(i); // R01 R04 R05 R06 R08 R09 R11
            end
        end
        else if (wr_en)
        begin
            cfg_all[wr_idx] <= (cfg_all[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

endmodule // pfs_cfg_store

//--- verif/pfs_periph_model.sv
module pfs_periph_model
    import pfs_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      freeze,
    output logic      [PFS_NPADS-1:0][3:0] periph_out,
    output logic      [PFS_NPADS-1:0][3:0] periph_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        periph_out = '0;
        periph_oe  = '0;
    end

    // every slot of every pad carries its own changing value
    always @(posedge ref_clk)
    begin
        if (!freeze)
        begin
            periph_out <= $urandom;
            periph_oe  <= $urandom;
        end
    end
endmodule // pfs_periph_model

//--- verif/pfs_pad_mux_tb.sv
module pfs_pad_mux_tb;
    import pfs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic                      ref_clk     = 1'b0;
    logic                      nrst        = 1'b0;
    logic                      wb_cyc_i    = 1'b0;
    logic                      wb_stb_i    = 1'b0;
    logic                      wb_we_i     = 1'b0;
    logic [7:0]                wb_adr_i    = 8'h00;
    logic [3:0]                wb_sel_i    = 4'h0;
    logic [31:0]               wb_dat_i    = 32'h0;
    logic                      boot_active = 1'b0;
    logic [PFS_NPADS-1:0]      pad_in      = 8'h00;
    logic                      freeze      = 1'b0;
    logic [31:0]               wb_dat_o;
    logic                      wb_ack_o;
    logic [PFS_NPADS-1:0][3:0] periph_out;
    logic [PFS_NPADS-1:0][3:0] periph_oe;
    logic [PFS_NPADS-1:0]      periph_in;
    logic [PFS_NPADS-1:0]      wakeup_line;
    logic [PFS_NPADS-1:0]      external_irq_line;
    logic                      nmi_req;
    logic [PFS_NPADS-1:0]      pad_out;
    logic [PFS_NPADS-1:0]      pad_oe;
    logic [PFS_NPADS-1:0]      pad_pull_up;
    logic [PFS_NPADS-1:0]      pad_drive_fast;
    logic [15:0]               sh [PFS_NPADS];
    logic [31:0]               q;
    int                        fail_count = 0;
    int                        n_compared = 0;

    always #10 ref_clk = ~ref_clk;

    pfs_periph_model u_model (.ref_clk(ref_clk), .freeze(freeze),
        .periph_out(periph_out), .periph_oe(periph_oe));

    pfs_pad_mux u_dut (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .boot_active(boot_active), .periph_out(periph_out), .periph_oe(periph_oe),
        .periph_in(periph_in), .wakeup_line(wakeup_line),
        .external_irq_line(external_irq_line), .nmi_req(nmi_req), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
        .pad_drive_fast(pad_drive_fast));

    task automatic stop_test();
        $display("errors %0d compares %0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        r = 32'h0;
        for (k = 0; k < 20; k++)
        begin
            @(posedge ref_clk);
            if (wb_ack_o === 1'b1)
                break;
        end
        if (k == 20)
        begin
            fail_count++;
            $display("Error %0t: no bus answer", $time);
            stop_test();
        end
        else
        begin
            r = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i  <= 1'b0;
        end
    endtask

    task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
        logic [15:0] m;
        logic [31:0] r;
        m = PFS_WMASK & {{8{s[1]}}, {8{s[0]}}};
        sh[i] = (sh[i] & ~m) | (d & m);
        wb(1'b1, 8'(i * 4), s, {16'h0, d}, r);
    endtask

    function automatic logic [2:0] ptype(input int i);
        case (i)
            0, 4, 7: return 3'h1;
            3:       return 3'h4;
            5:       return 3'h0;
            default: return 3'h2;
        endcase
    endfunction

    task automatic check_all();
        logic [1:0]  sl;
        logic        eo;
        logic        eoe;
        logic [31:0] r;
        freeze <= 1'b1;
        repeat (6) @(negedge ref_clk);
        for (int i = 0; i < PFS_NPADS; i++)
        begin
            sl = sh[i][1:0];
            eo = 1'b0;
            eoe = 1'b0;
            if ((i == PFS_PAD_NMI && sh[i][PFS_BIT_NMI]) ||
                (i == PFS_PAD_WAKE && sl == PFS_BOOT_SLOT && !boot_active))
                eoe = 1'b0;
            else if (sl == 2'h0)
            begin
                eo = periph_out[i][0];
                eoe = sh[i][PFS_BIT_OBE];
            end
            else
            begin
                eo = periph_out[i][sl];
                eoe = periph_oe[i][sl];
            end
            chk({pad_out[i], pad_oe[i]}, {eo, eoe});
            chk({pad_pull_up[i], pad_drive_fast[i], periph_in[i]}, {sh[i][PFS_BIT_PULL],
                sh[i][PFS_BIT_FAST] && i == 5, pad_in[i] & sh[i][PFS_BIT_IBE]});
        end
        chk({wakeup_line, external_irq_line, nmi_req}, {pad_in & PFS_WAKE_MASK,
            pad_in & (PFS_WAKE_MASK | PFS_EXTERNAL_IRQ_LINE_MASK), sh[1][PFS_BIT_NMI] & pad_in[1]});
        for (int i = 0; i < PFS_NPADS; i++)
        begin
            wb(1'b0, 8'(i * 4), 4'hf, 32'h0, r);
            chk(r, {16'h0, pad_in[i], ptype(i), sh[i][11:0]});
        end
        freeze <= 1'b0;
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({pad_oe, pad_pull_up, pad_drive_fast}, {8'h00, 8'hc0, 8'h00});
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < PFS_NPADS; i++)
            sh[i] = (i == PFS_PAD_TDI) ? PFS_RST_TDI : (i == PFS_PAD_TDO) ? PFS_RST_TDO :
                    (i >= PFS_PAD_TCK) ? PFS_RST_SCAN : PFS_RST_GPIO;
        nrst <= 1'b1;
    endtask

    initial
    begin
        void'($urandom(54535));
        do_reset();
        check_all();
        wb(1'b1, 8'h20, 4'hf, 32'hffff, q);
        wb(1'b0, 8'h20, 4'hf, 32'h0, q);
        chk(q, 32'h0);
        wr(PFS_PAD_TDO, 16'h0200, 4'h3);
        check_all();
        wr(PFS_PAD_NMI, 16'h0005, 4'h3);
        pad_in <= 8'h0e;
        check_all();
        // boot-only function selected with the input buffer bit kept clear
        wr(PFS_PAD_WAKE, 16'h0003, 4'h3);
        boot_active <= 1'b1;
        check_all();
        boot_active <= 1'b0;
        check_all();
        // software hands the scan pads back to general-purpose use
        for (int i = PFS_PAD_TDI; i < PFS_NPADS; i++)
            wr(i, 16'h0000, 4'h3);
        check_all();
        repeat (40)
        begin
            boot_active <= 1'($urandom);
            pad_in <= 8'($urandom);
            wr(int'($urandom_range(7)), 16'($urandom), 4'($urandom));
            check_all();
        end
        do_reset();
        check_all();
        stop_test();
    end
endmodule // pfs_pad_mux_tb
